//--- design/frvcd_pkg.sv
// Shared constants, states and carriers of the read-class command decoder
package frvcd_pkg;

	// ==========================================================
	// Opcodes in the low five bits of the first command byte
	localparam logic [4:0] OPC_READ_DATA  = 5'h06;
	localparam logic [4:0] OPC_READ_DEL   = 5'h0c;
	localparam logic [4:0] OPC_READ_TRACK = 5'h02;
	localparam logic [4:0] OPC_READ_ID    = 5'h0a;
	localparam logic [4:0] OPC_VERIFY     = 5'h16;

	// ==========================================================
	// Field positions
	localparam int OPT_MULTI_TRACK_BIT = 7;
	localparam int OPT_DENSITY_BIT     = 6;
	localparam int OPT_SKIP_BIT        = 5;
	localparam int COUNT_FLAG_BIT      = 7;
	localparam int HEAD_SELECT_BIT     = 2;
	localparam int ST2_CONTROL_MARK    = 6;
	localparam int ST1_NO_DATA         = 2;

	// Parameter byte positions within a command
	localparam logic [3:0] PRM_SELECT = 4'h1;
	localparam logic [3:0] PRM_CYL    = 4'h2;
	localparam logic [3:0] PRM_HEAD   = 4'h3;
	localparam logic [3:0] PRM_REC    = 4'h4;
	localparam logic [3:0] PRM_SIZE   = 4'h5;
	localparam logic [3:0] PRM_LAST   = 4'h6;
	localparam logic [3:0] PRM_LEN    = 4'h8;

	// ==========================================================
	// Counts and values after reset
	localparam logic [3:0] CMD_LEN_DATA   = 4'h9;
	localparam logic [3:0] CMD_LEN_ID     = 4'h2;
	localparam logic [2:0] RESULT_LAST    = 3'h6;
	localparam logic [1:0] INDEX_LIMIT    = 2'h2;
	localparam logic [1:0] IC_NORMAL      = 2'h0;
	localparam logic [1:0] IC_ABNORMAL    = 2'h1;
	localparam logic [1:0] IC_INVALID     = 2'h2;
	localparam logic [7:0] BYTE_RESET     = 8'h00;
	localparam logic [7:0] REC_FIRST      = 8'h01;

	// ==========================================================
	// States, one-hot
	typedef enum logic [4:0] {
		ST_IDLE   = 5'b00001,
		ST_PARAM  = 5'b00010,
		ST_FIND   = 5'b00100,
		ST_XFER   = 5'b01000,
		ST_RESULT = 5'b10000
	} frvcd_state_t;

	// Sector identity field
	typedef struct packed {
		logic [7:0] c;
		logic [7:0] h;
		logic [7:0] r;
		logic [7:0] n;
	} frvcd_id_t;

	// One byte from the data separator
	typedef struct packed {
		logic [7:0] data;
		logic       last;
		logic       deleted;
	} frvcd_sector_t;

endpackage

//--- design/frvcd_decoder.sv
// Read-class floppy command decoder, sequencer and result generator
`timescale 1ns/10ps
// How it works
// - Read data opcode 00110 with three option bits
// - Select, identity, last, gap, length bytes precede execution
// - Result opens with status zero, one, two
// - Then cylinder, head, record, size reached
// - Read deleted data uses opcode 01100
// - Read track reads index through last sector
// - Read identity captures first good identity field
// - Read identity returns status then captured identity
// - Verify opcode 10110, count flag, no transfer
// - Skip option passes over sectors of the unwanted data mark, except in read track
// - Command, execution, result phases in sequence
// - Second byte low bits select drive
// - Second byte bit two selects head
// - Last sector number ends multi-sector transfer
module frvcd_decoder (
	input  wire logic                    clock,
	input  wire logic                    rst_b,
	input  wire logic                    cmd_valid,
	input  wire logic [7:0]              cmd_byte,
	output logic                         cmd_ready,
	output logic                         res_valid,
	output logic [7:0]                   res_byte,
	input  wire logic                    res_ready,
	input  wire logic                    id_valid,
	input  wire frvcd_pkg::frvcd_id_t    id_field,
	input  wire logic                    id_crc_ok,
	input  wire logic                    index_pulse,
	input  wire logic                    sec_valid,
	input  wire frvcd_pkg::frvcd_sector_t sec_in,
	output logic                         sec_ready,
	output logic                         xfer_valid,
	output logic [7:0]                   xfer_byte,
	input  wire logic                    xfer_ready,
	output logic [1:0]                   drive_sel,
	output logic                         head_sel,
	output logic                         density_sel,
	output logic                         exec_busy
);
	import frvcd_pkg::*;

	// ==========================================================
	// State
	typedef struct packed {
		frvcd_state_t    state;
		logic [7:0]      opt;
		logic [8:0][7:0] prm;
		logic [3:0]      pcnt;
		frvcd_id_t       cur;
		logic [1:0]      idx_cnt;
		logic            started;
		logic [7:0]      done_cnt;
		logic [1:0]      ic;
		logic            no_data;
		logic            cmark;
		logic [2:0]      res_idx;
		logic [2:0]      res_last;
		logic            res_valid;
		logic [7:0]      res_byte;
		logic            cmd_ready;
		logic [1:0][7:0] buf_d;
		logic [1:0]      buf_v;
		logic [1:0]      drive_sel;
		logic            head_sel;
		logic            dens;
		logic            busy;
		logic            sec_rdy;
	} frvcd_reg_t;

	frvcd_reg_t st_reg;
	frvcd_reg_t st_next;

	// ==========================================================
	// Result byte for a given position
	function automatic logic [7:0] result_at(input frvcd_reg_t s,
		input logic [2:0] i);
		logic [7:0] b;
		b = BYTE_RESET;
		case (i)
			3'h0: begin
				b = {s.ic, 3'b000, s.head_sel, s.drive_sel};
			end
			3'h1: begin
				b[ST1_NO_DATA] = s.no_data;
			end
			3'h2: begin
				b[ST2_CONTROL_MARK] = s.cmark;
			end
			3'h3: b = s.cur.c;
			3'h4: b = s.cur.h;
			3'h5: b = s.cur.r;
			3'h6: b = s.cur.n;
			default: b = BYTE_RESET;
		endcase
		return b;
	endfunction

	logic [4:0]  opc;
	logic        want_del;
	logic        mismatch;
	logic        pop;
	logic        push;
	logic [7:0]  push_d;
	logic        finish;
	logic [1:0]  fin_ic;

	always_comb begin
		st_next = st_reg;
		opc = st_reg.opt[4:0];
		want_del = (opc == OPC_READ_DEL);
		mismatch = sec_in.deleted != want_del;
		pop = st_reg.buf_v[0] && xfer_ready;
		push = 1'b0;
		push_d = sec_in.data;
		finish = 1'b0;
		fin_ic = IC_NORMAL;

		case (st_reg.state)
			ST_IDLE: begin
				if (cmd_valid) begin
					st_next.opt = cmd_byte;
					st_next.ic = IC_NORMAL;
					st_next.no_data = 1'b0;
					st_next.cmark = 1'b0;
					st_next.pcnt = PRM_SELECT;
					st_next.res_idx = 3'h0;
					st_next.busy = 1'b1;
					st_next.dens = cmd_byte[OPT_DENSITY_BIT];
					case (cmd_byte[4:0])
						OPC_READ_DATA, OPC_READ_DEL, OPC_READ_TRACK,
						OPC_READ_ID, OPC_VERIFY: begin
							st_next.state = ST_PARAM;
						end
						default: begin
							st_next.ic = IC_INVALID;
							st_next.res_last = 3'h0;
							st_next.res_byte = {IC_INVALID, 6'h00};
							st_next.res_valid = 1'b1;
							st_next.cmd_ready = 1'b0;
							st_next.state = ST_RESULT;
						end
					endcase
				end
			end
			ST_PARAM: begin
				if (cmd_valid) begin
					st_next.prm[st_reg.pcnt] = cmd_byte;
					st_next.pcnt = st_reg.pcnt + 4'h1;
					if (st_reg.pcnt == PRM_SELECT) begin
						st_next.drive_sel = cmd_byte[1:0];
						st_next.head_sel = cmd_byte[HEAD_SELECT_BIT];
					end
					if (st_reg.pcnt + 4'h1 == ((opc == OPC_READ_ID) ?
						CMD_LEN_ID : CMD_LEN_DATA)) begin
						st_next.cmd_ready = 1'b0;
						st_next.state = ST_FIND;
						st_next.idx_cnt = 2'h0;
						st_next.started = 1'b0;
						st_next.done_cnt = BYTE_RESET;
						if (opc != OPC_READ_ID) begin
							st_next.cur = {st_reg.prm[PRM_CYL],
								st_reg.prm[PRM_HEAD], st_reg.prm[PRM_REC],
								st_reg.prm[PRM_SIZE]};
						end
					end
				end
			end
			ST_FIND: begin
				if (index_pulse) begin
					st_next.started = 1'b1;
					st_next.idx_cnt = st_reg.idx_cnt + 2'h1;
					// Two index pulses without a matching sector means no data
					if (st_reg.idx_cnt + 2'h1 == INDEX_LIMIT &&
						!(opc == OPC_READ_TRACK && st_reg.done_cnt != 8'h00)) begin
						st_next.no_data = 1'b1;
						finish = 1'b1;
						fin_ic = IC_ABNORMAL;
					end
				end else if (id_valid && id_crc_ok) begin
					if (opc == OPC_READ_ID) begin
						st_next.cur = id_field;
						finish = 1'b1;
					end else if (opc == OPC_READ_TRACK) begin
						if (st_reg.started) begin
							st_next.cur = id_field;
							st_next.state = ST_XFER;
						end
					end else if (id_field.r == st_reg.cur.r) begin
						st_next.state = ST_XFER;
					end
				end
			end
			ST_XFER: begin
				// Same test as the registered sec_ready, so no byte is lost
				if (sec_valid && st_reg.buf_v[1] == 1'b0) begin
					// Verify moves nothing; skipped sectors of the unwanted data mark are dropped
					push = opc != OPC_VERIFY &&
						!(mismatch && st_reg.opt[OPT_SKIP_BIT] &&
						opc != OPC_READ_TRACK);
					if (sec_in.last) begin
						st_next.done_cnt = st_reg.done_cnt + 8'h01;
						st_next.idx_cnt = 2'h0;
						st_next.state = ST_FIND;
						st_next.cur.r = st_reg.cur.r + 8'h01;
						if (mismatch && !st_reg.opt[OPT_SKIP_BIT] &&
							opc != OPC_READ_TRACK) begin
							st_next.cmark = 1'b1;
							finish = 1'b1;
						end else if (opc == OPC_VERIFY &&
							st_reg.prm[PRM_SELECT][COUNT_FLAG_BIT]) begin
							finish = st_reg.done_cnt + 8'h01 ==
								st_reg.prm[PRM_LEN];
						end else if (st_reg.cur.r == st_reg.prm[PRM_LAST]) begin
							if (st_reg.opt[OPT_MULTI_TRACK_BIT] && opc !=
								OPC_READ_TRACK && !st_reg.head_sel) begin
								st_next.head_sel = 1'b1;
								st_next.cur.h = st_reg.cur.h + 8'h01;
								st_next.cur.r = REC_FIRST;
							end else begin
								finish = 1'b1;
							end
						end
					end
				end
			end
			ST_RESULT: begin
				if (res_ready && st_reg.res_valid) begin
					if (st_reg.res_idx == st_reg.res_last) begin
						st_next.res_valid = 1'b0;
						st_next.busy = 1'b0;
						st_next.cmd_ready = 1'b1;
						st_next.state = ST_IDLE;
					end else begin
						st_next.res_idx = st_reg.res_idx + 3'h1;
						st_next.res_byte = result_at(st_reg,
							st_reg.res_idx + 3'h1);
					end
				end
			end
			default: begin
				st_next.state = ST_IDLE;
			end
		endcase

		if (finish) begin
			st_next.ic = fin_ic;
			st_next.state = ST_RESULT;
			st_next.res_idx = 3'h0;
			st_next.res_last = RESULT_LAST;
			st_next.res_valid = 1'b1;
			st_next.res_byte = {fin_ic, 3'b000, st_reg.head_sel,
				st_reg.drive_sel};
		end

		// Two-entry buffer: the drive side is held off while it is full
		if (pop) begin
			st_next.buf_d[0] = st_reg.buf_d[1];
			st_next.buf_v = {1'b0, st_reg.buf_v[1]};
		end
		if (push) begin
			if (st_next.buf_v[0]) begin
				st_next.buf_d[1] = push_d;
				st_next.buf_v[1] = 1'b1;
			end else begin
				st_next.buf_d[0] = push_d;
				st_next.buf_v[0] = 1'b1;
			end
		end

		// Registered, so the drive sees a plain flop and no decode glitch;
		// taken from the next state, so it still falls as the buffer fills
		st_next.sec_rdy = st_next.state == ST_XFER && !st_next.buf_v[1];
	end

	always_ff @(posedge clock) begin
		if (!rst_b) begin
			st_reg <= '0;
			st_reg.state <= ST_IDLE;
			st_reg.cmd_ready <= 1'b1;
		end else begin
			st_reg <= st_next;
		end
	end

	// ==========================================================
	// Outputs
	assign cmd_ready   = st_reg.cmd_ready;
	assign res_valid   = st_reg.res_valid;
	assign res_byte    = st_reg.res_byte;
	assign sec_ready   = st_reg.sec_rdy;
	assign xfer_valid  = st_reg.buf_v[0];
	assign xfer_byte   = st_reg.buf_d[0];
	assign drive_sel   = st_reg.drive_sel;
	assign head_sel    = st_reg.head_sel;
	assign density_sel = st_reg.dens;
	assign exec_busy   = st_reg.busy;

endmodule

//--- tb/frvcd_monitor.sv
// Port checker for the read-class command decoder
`timescale 1ns/10ps
module frvcd_monitor
	import frvcd_pkg::*;
(
	input wire logic       clock,
	input wire logic       rst_b,
	input wire logic       cmd_valid,
	input wire logic [7:0] cmd_byte,
	input wire logic       cmd_ready,
	input wire logic       res_valid,
	input wire logic [7:0] res_byte,
	input wire logic       res_ready,
	input wire logic       sec_ready,
	input wire logic       xfer_valid,
	input wire logic [7:0] xfer_byte,
	input wire logic       xfer_ready,
	input wire logic [1:0] drive_sel,
	input wire logic       head_sel,
	input wire logic       exec_busy
);
	// ==========================================================
	// Bytes taken and opcode of the command in progress
	logic [3:0] cnt_reg;
	logic [4:0] op_reg;
	always_ff @(posedge clock) begin
		if (!rst_b || (!exec_busy && !(cmd_valid && cmd_ready))) begin
			cnt_reg <= 4'h0;
			op_reg  <= 5'h00;
		end else if (cmd_valid && cmd_ready) begin
			cnt_reg <= cnt_reg + 4'h1;
			if (cnt_reg == 4'h0)
				op_reg <= cmd_byte[4:0];
		end
	end
	default clocking cb @(posedge clock);
	endclocking
	default disable iff (!rst_b);
	// ==========================================================
	// Properties
	sequence s_take;
		cmd_valid && cmd_ready;
	endsequence
	sequence s_last_res;
		res_valid && res_ready ##1 !res_valid;
	endsequence
	property p_busy;
		cmd_valid && cmd_ready && !exec_busy |=> exec_busy;
	endproperty
	property p_sel;
		s_take ##0 cnt_reg == 4'h1 |=> drive_sel == $past(cmd_byte[1:0])
			&& head_sel == $past(cmd_byte[2]);
	endproperty
	property p_end;
		s_take ##0 cnt_reg == ((op_reg == OPC_READ_ID) ? 4'h1 : 4'h8)
			|=> !cmd_ready;
	endproperty
	property p_phase;
		res_valid || sec_ready |-> !cmd_ready;
	endproperty
	property p_quiet;
		op_reg == OPC_VERIFY || op_reg == OPC_READ_ID |-> !xfer_valid;
	endproperty
	property p_res_hold;
		res_valid && !res_ready |=> res_valid && $stable(res_byte);
	endproperty
	property p_xfer_hold;
		xfer_valid && !xfer_ready |=> xfer_valid && $stable(xfer_byte);
	endproperty
	property p_done;
		s_last_res |-> cmd_ready && !exec_busy;
	endproperty
	a_busy: assert property (p_busy)
		else $error("busy late");
	a_sel: assert property (p_sel)
		else $error("select wrong");
	a_end: assert property (p_end)
		else $error("ready after last byte");
	a_phase: assert property (p_phase)
		else $error("phases overlap");
	a_quiet: assert property (p_quiet)
		else $error("data moved");
	a_res_hold: assert property (p_res_hold)
		else $error("result moved");
	a_xfer_hold: assert property (p_xfer_hold)
		else $error("data byte moved");
	a_done: assert property (p_done)
		else $error("no return to idle");
endmodule

//--- tb/frvcd_drive_model.sv
// Behavioural disk drive feeding identity fields and sector bytes
`timescale 1ns/10ps
module frvcd_drive_model
	import frvcd_pkg::*;
(
	input  wire logic           clock,
	input  wire logic           spin,
	input  wire logic           head,
	input  wire logic [3:0]     del_mask,
	input  wire logic           sec_ready,
	input  wire logic           crc_fault,
	output logic                index_pulse,
	output logic                id_valid,
	output frvcd_pkg::frvcd_id_t id_field,
	output logic                id_crc_ok,
	output logic                sec_valid,
	output frvcd_pkg::frvcd_sector_t sec_in
);
	int r;
	int b;
	int w;
	// ==========================================================
	// One turn: index, then four sectors of two bytes
	initial begin
		{index_pulse, id_valid, sec_valid} = 3'h0;
		id_crc_ok = 1'b1;
		id_field  = 32'h0;
		sec_in    = 10'h0;
		forever begin
			@(negedge clock);
			if (spin) begin
				index_pulse = 1'b1;
				@(negedge clock);
				index_pulse = 1'b0;
				for (r = 1; r <= 4; r++) begin
					repeat (3) @(negedge clock);
					id_field = {8'h03, 7'h00, head, r[7:0], 8'h01};
					// Under crc_fault only record three reads back clean
					id_crc_ok = !crc_fault || r == 3;
					id_valid = 1'b1;
					@(negedge clock);
					id_valid = 1'b0;
					id_field = ~id_field;
					for (b = 0; b < 2; b++) begin
						sec_in = {r[3:0], b[3:0], b == 1, del_mask[r - 1]};
						sec_valid = 1'b1;
						// Disk keeps turning: a byte waits a few cycles only
						for (w = 0; w < 8 && !sec_ready; w++)
							@(negedge clock);
						@(negedge clock);
					end
					sec_valid = 1'b0;
					sec_in.data = ~sec_in.data;
				end
			end
		end
	end
endmodule

//--- tb/frvcd_decoder_bench.sv
// Self-checking bench of the read-class command decoder
`timescale 1ns/10ps
module frvcd_decoder_bench;
	import frvcd_pkg::*;
	typedef struct {
		logic [7:0] op, sel, rec, last_sector_number;
		logic [3:0] mask;
		logic [7:0] nx, st0, rres;
	} frvcd_row_t;
	logic          clock = 1'b0;
	logic          rst_b = 1'b0;
	logic          cmd_valid = 1'b0;
	logic [7:0]    cmd_byte = 8'h00;
	logic          take_ok = 1'b0;
	logic [3:0]    del_mask = 4'h0;
	logic          crc_fault = 1'b0;
	logic [7:0]    x_last = 8'h00;
	logic          cmd_ready, res_valid, sec_ready, xfer_valid, exec_busy;
	logic          id_valid, id_crc_ok, index_pulse, sec_valid;
	logic          head_sel, density_sel;
	logic [7:0]    res_byte, xfer_byte;
	logic [1:0]    drive_sel;
	frvcd_id_t     id_field;
	frvcd_sector_t sec_in;
	logic [7:0]    q[$];
	int            n_errors = 0;
	int            n_tests = 0;
	int            n_x = 0;
	// Read identity goes first: only then is the disk phase known
	frvcd_row_t rows[8] = '{
		'{8'h4a, 8'h04, 8'h00, 8'h00, 4'h0, 8'h00, 8'h04, 8'h01},
		'{8'h46, 8'h00, 8'h01, 8'h02, 4'h0, 8'h04, 8'h00, 8'h03},
		'{8'h4c, 8'h05, 8'h01, 8'h02, 4'hf, 8'h04, 8'h05, 8'h03},
		'{8'h66, 8'h02, 8'h01, 8'h02, 4'h1, 8'h02, 8'h02, 8'h03},
		'{8'h42, 8'h00, 8'h01, 8'h02, 4'h0, 8'h04, 8'h00, 8'h03},
		'{8'h56, 8'h00, 8'h01, 8'h02, 4'h0, 8'h00, 8'h00, 8'h03},
		'{8'h56, 8'h80, 8'h01, 8'h04, 4'h0, 8'h00, 8'h00, 8'h02},
		'{8'hc6, 8'h00, 8'h01, 8'h02, 4'h0, 8'h08, 8'h04, 8'h03}
	};
	always #20 clock = ~clock;
	frvcd_decoder dut (.clock, .rst_b, .cmd_valid, .cmd_byte, .cmd_ready,
		.res_valid, .res_byte, .res_ready(take_ok), .id_valid, .id_field,
		.id_crc_ok, .index_pulse, .sec_valid, .sec_in, .sec_ready,
		.xfer_valid, .xfer_byte, .xfer_ready(take_ok), .drive_sel,
		.head_sel, .density_sel, .exec_busy);
	frvcd_drive_model u_drive (.clock, .spin(exec_busy), .head(head_sel),
		.del_mask, .sec_ready, .crc_fault, .index_pulse, .id_valid,
		.id_field, .id_crc_ok, .sec_valid, .sec_in);
	// ==========================================================
	// Host side: half-rate taker stalls both outputs
	always @(negedge clock) begin
		take_ok = ~take_ok;
		if (res_valid && take_ok)
			q.push_back(res_byte);
		if (xfer_valid && take_ok) begin
			x_last = xfer_byte;
			n_x++;
		end
	end
	task automatic check(input logic [7:0] got, exp, input string what);
		n_tests++;
		if (got !== exp) begin
			n_errors++;
			$display("Error at %0t: %s got %h want %h", $time, what, got, exp);
		end
	endtask
	task automatic send(input logic [7:0] b);
		cmd_valid = 1'b1;
		cmd_byte  = b;
		while (!cmd_ready)
			@(negedge clock);
		@(negedge clock);
	endtask
	task automatic run(input frvcd_row_t r, input int n);
		logic [7:0] p[7];
		int         i;
		p = '{8'h03, {7'h00, r.sel[2]}, r.rec, 8'h01, r.last_sector_number, 8'h1b,
			r.sel[7] ? 8'h01 : 8'hff};
		q = {};
		n_x = 0;
		x_last = 8'h00;
		del_mask = r.mask;
		send(r.op);
		if (n > 1)
			send(r.sel);
		if (n > 1 && r.op[4:0] != OPC_READ_ID)
			foreach (p[j])
				send(p[j]);
		cmd_valid = 1'b0;
		for (i = 0; i < 3000 && q.size() < n; i++)
			@(negedge clock);
		repeat (4) @(negedge clock);
	endtask
	task automatic conclude();
		$display("Checks %0d, errors %0d", n_tests, n_errors);
		if (n_errors == 0 && n_tests > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask
	// ==========================================================
	// Table of commands, then the awkward cases
	initial begin
		repeat (20) @(negedge clock);
		check({3'h0, cmd_ready, exec_busy, res_valid, xfer_valid, sec_ready},
			8'h10, "reset");
		rst_b = 1'b1;
		foreach (rows[k]) begin
			run(rows[k], 7);
			check(q[0], rows[k].st0, "st0");
			check(q[3], 8'h03, "cyl");
			check(q[5], rows[k].rres, "rec");
			check(q[6], 8'h01, "size");
			check(n_x[7:0], rows[k].nx, "bytes");
			check({7'h0, density_sel}, {7'h0, rows[k].op[6]},
				"density");
			if (rows[k].nx != 8'h00)
				check(x_last, {rows[k].rres[3:0] - 4'h1, 4'h1},
					"data");
			check({5'h0, head_sel, drive_sel}, {5'h0, rows[k].st0[2:0]},
				"select");
			if (!rows[k].op[5])
				check(q[1] | q[2], 8'h00, "st1 st2");
		end
		run('{8'h1f, 8'h00, 8'h00, 8'h00, 4'h0, 8'h00, 8'h00, 8'h00}, 1);
		check(q[0], 8'h80, "invalid");
		check(8'(q.size()), 8'h01, "count");
		check({7'h0, cmd_ready}, 8'h01, "ready");
		run('{8'h06, 8'h00, 8'h01, 8'h02, 4'h1, 8'h02, 8'h00, 8'h02}, 7);
		check(q[2], 8'h40, "mark");
		check(q[5], 8'h02, "mark rec");
		check(n_x[7:0], 8'h02, "mark bytes");
		check({7'h0, density_sel}, 8'h00, "density");
		crc_fault = 1'b1;
		run('{8'h4a, 8'h00, 8'h00, 8'h00, 4'h0, 8'h00, 8'h00, 8'h00}, 7);
		check(q[5], 8'h03, "good id");
		crc_fault = 1'b0;
		run('{8'h46, 8'h01, 8'h09, 8'h09, 4'h0, 8'h00, 8'h41, 8'h00}, 7);
		check(q[0], 8'h41, "not found");
		check(q[1] & 8'h04, 8'h04, "no data");
		conclude();
	end
	initial begin
		#400000;
		n_errors++;
		$display("Error at %0t: run timed out", $time);
		conclude();
	end
endmodule
bind frvcd_decoder frvcd_monitor u_mon (.clock, .rst_b, .cmd_valid,
	.cmd_byte, .cmd_ready, .res_valid, .res_byte, .res_ready, .sec_ready,
	.xfer_valid, .xfer_byte, .xfer_ready, .drive_sel, .head_sel,
	.exec_busy);
